// file: design/pin_mux_regs.svh
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH
// port d line numbering, lines 1..7 used
`define PD_LINE_CAN         1
`define PD_LINE_TX1         6
`define PD_LINE_RX1         7
// global peripheral select field
`define GPS_LINE1_SEL_BIT   5
// port e line numbering
`define PE_LINE_TX0         0
`define PE_LINE_RX0         1
// reset values
`define PD_PER_RST          8'hc0
`define PE_PER_RST          2'h3
`define PD_PULLUP_RST       8'hfe
`define PE_PULLUP_RST       2'h3
`endif

// file: design/pin_mux_pkg.sv
package pin_mux_pkg;
	typedef logic [7:0] pd_vec_t;
	typedef logic [1:0] pe_vec_t;
	typedef struct packed {
		pd_vec_t pd_out;
		pd_vec_t pd_oe;
		pd_vec_t pd_pu;
		pd_vec_t pd_in;
		pe_vec_t pe_out;
		pe_vec_t pe_oe;
		pe_vec_t pe_pu;
		pe_vec_t pe_in;
		logic    can_rx;
		logic    rx0;
		logic    rx1;
	} mux_state_s;
endpackage : pin_mux_pkg

// file: design/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] dout_ff;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= '1;
			dout_ff <= '1;
		end
		else
		begin
			meta_ff <= din;
			dout_ff <= meta_ff;
		end
	end
	assign dout = dout_ff;
endmodule : pin_sync

// file: design/port_d_e_pin_function_mux.sv
`timescale 1ns/10ps
`include "pin_mux_regs.svh"
// Summary of operation
// - each gpio line independently input or output
// - port d line1 resets to gpio
// - enable bit1 then select bit5 picks function
// - chip selects driven by memory interface
// - chip selects tristate idle per drive bit
// - port d lines 2-5 reset to gpio
// - port d pull-up bit n controls line n
// - second can receive pulled up via bit1
// - port e line0 resets to serial transmit
// - port e pull-up bits 0,1 serial0 pins
// - port d line7 resets to serial receive
// - port d pull-up bits 6,7 serial1 pins
module port_d_e_pin_function_mux (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// software control bits
	input  wire logic [7:0] port_d_peripheral_enable,
	input  wire logic [1:0] port_e_peripheral_enable,
	input  wire logic [7:0] global_peripheral_select,
	input  wire logic [7:0] port_d_pullup_enable,
	input  wire logic [1:0] port_e_pullup_enable,
	input  wire logic [7:0] port_d_gpio_dir,
	input  wire logic [7:0] port_d_gpio_data,
	input  wire logic [1:0] port_e_gpio_dir,
	input  wire logic [1:0] port_e_gpio_data,
	input  wire logic       bus_drive_control,
	// external memory interface
	input  wire logic [7:3] chip_select_n,
	input  wire logic       ext_bus_active,
	// serial ports
	input  wire logic       serial0_transmit,
	input  wire logic       serial1_transmit,
	output logic            serial0_receive,
	output logic            serial1_receive,
	output logic            second_can_receive,
	// gpio read-back
	output logic [7:0]      port_d_gpio_in,
	output logic [1:0]      port_e_gpio_in,
	// pads
	input  wire logic [7:0] port_d_pad_in,
	output logic [7:0]      port_d_pad_out,
	output logic [7:0]      port_d_pad_oe,
	output logic [7:0]      port_d_pad_pullup,
	input  wire logic [1:0] port_e_pad_in,
	output logic [1:0]      port_e_pad_out,
	output logic [1:0]      port_e_pad_oe,
	output logic [1:0]      port_e_pad_pullup
);
	//////////////////////////////////////////////////////////////////////////////
	// pad input synchronisers
	logic [9:0] pad_sync;
	pin_sync #(
		.WIDTH (10)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({port_e_pad_in, port_d_pad_in}),
		.dout    (pad_sync)
	);
	//////////////////////////////////////////////////////////////////////////////
	// state
	pin_mux_pkg::mux_state_s state_ff;
	pin_mux_pkg::mux_state_s nxt_state;
	logic                    line1_is_cs;
	logic                    cs_drive;
	always_comb
	begin
		nxt_state = state_ff;
		line1_is_cs = !global_peripheral_select[`GPS_LINE1_SEL_BIT];
		cs_drive = ext_bus_active || bus_drive_control;
		// gpio default on every line
		nxt_state.pd_out = port_d_gpio_data;
		nxt_state.pd_oe = port_d_gpio_dir;
		nxt_state.pe_out = port_e_gpio_data;
		nxt_state.pe_oe = port_e_gpio_dir;
		nxt_state.pd_pu = port_d_pullup_enable;
		nxt_state.pe_pu = port_e_pullup_enable;
		nxt_state.pd_in = pad_sync[7:0];
		nxt_state.pe_in = pad_sync[9:8];
		nxt_state.can_rx = 1'b1;
		nxt_state.rx0 = 1'b1;
		nxt_state.rx1 = 1'b1;
		// line1: chip select 3 or second can receive
		if (port_d_peripheral_enable[`PD_LINE_CAN])
		begin
			if (line1_is_cs)
			begin
				nxt_state.pd_out[1] = chip_select_n[3];
				nxt_state.pd_oe[1] = cs_drive;
			end
			else
			begin
				nxt_state.pd_oe[1] = 1'b0;
				nxt_state.can_rx = pad_sync[1];
			end
		end
		// lines 2..5: chip selects 4..7
		for (int i = 2; i <= 5; i++)
		begin
			if (port_d_peripheral_enable[i])
			begin
				nxt_state.pd_out[i] = chip_select_n[i+2];
				nxt_state.pd_oe[i] = cs_drive;
			end
		end
		// line6 serial1 transmit, line7 serial1 receive
		if (port_d_peripheral_enable[`PD_LINE_TX1])
		begin
			nxt_state.pd_out[6] = serial1_transmit;
			nxt_state.pd_oe[6] = 1'b1;
		end
		if (port_d_peripheral_enable[`PD_LINE_RX1])
		begin
			nxt_state.pd_oe[7] = 1'b0;
			nxt_state.rx1 = pad_sync[7];
		end
		// port e serial0
		if (port_e_peripheral_enable[`PE_LINE_TX0])
		begin
			nxt_state.pe_out[0] = serial0_transmit;
			nxt_state.pe_oe[0] = 1'b1;
		end
		if (port_e_peripheral_enable[`PE_LINE_RX0])
		begin
			nxt_state.pe_oe[1] = 1'b0;
			nxt_state.rx0 = pad_sync[9];
		end
	end
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_ff.pd_out <= 8'h00;
			state_ff.pd_oe <= 8'h00;
			state_ff.pd_pu <= `PD_PULLUP_RST;
			state_ff.pd_in <= 8'hff;
			state_ff.pe_out <= 2'h3;
			state_ff.pe_oe <= 2'h0;
			state_ff.pe_pu <= `PE_PULLUP_RST;
			state_ff.pe_in <= 2'h3;
			state_ff.can_rx <= 1'b1;
			state_ff.rx0 <= 1'b1;
			state_ff.rx1 <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end
	assign port_d_pad_out = state_ff.pd_out;
	assign port_d_pad_oe = state_ff.pd_oe;
	assign port_d_pad_pullup = state_ff.pd_pu;
	assign port_e_pad_out = state_ff.pe_out;
	assign port_e_pad_oe = state_ff.pe_oe;
	assign port_e_pad_pullup = state_ff.pe_pu;
	assign port_d_gpio_in = state_ff.pd_in;
	assign port_e_gpio_in = state_ff.pe_in;
	assign second_can_receive = state_ff.can_rx;
	assign serial0_receive = state_ff.rx0;
	assign serial1_receive = state_ff.rx1;
	//////////////////////////////////////////////////////////////////////////////
	// checks
	gpio_dir_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_d_peripheral_enable[2] |=> port_d_pad_oe[2] == $past(port_d_gpio_dir[2]))
		else $error("gpio direction not followed");
	line1_gpio_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_d_peripheral_enable[1] |=> port_d_pad_out[1] == $past(port_d_gpio_data[1]) && second_can_receive)
		else $error("line1 not gpio while enable clear");
	cs3_route_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[1] && !global_peripheral_select[5] |=> port_d_pad_out[1] == $past(chip_select_n[3]))
		else $error("chip select 3 not routed");
	can_route_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[1] && global_peripheral_select[5] |=> !port_d_pad_oe[1])
		else $error("can receive line driven");
	cs_tristate_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[5] && !ext_bus_active && !bus_drive_control |=> !port_d_pad_oe[5])
		else $error("chip select 7 driven while idle");
	cs7_route_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[5] |=> port_d_pad_out[5] == $past(chip_select_n[7]))
		else $error("chip select 7 not routed");
	pullup_d_a: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> port_d_pad_pullup == $past(port_d_pullup_enable))
		else $error("port d pull-up mismatch");
	pullup_e_a: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> port_e_pad_pullup == $past(port_e_pullup_enable))
		else $error("port e pull-up mismatch");
	tx0_route_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_e_peripheral_enable[0] |=> port_e_pad_oe[0] && port_e_pad_out[0] == $past(serial0_transmit))
		else $error("serial0 transmit not routed");
	rx1_route_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[7] |=> !port_d_pad_oe[7])
		else $error("serial1 receive pad driven");
	cs4_route_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[2] |=> port_d_pad_out[2] == $past(chip_select_n[4]))
		else $error("chip select 4 not routed");
	cs_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[2] && (ext_bus_active || bus_drive_control) |=> port_d_pad_oe[2])
		else $error("chip select 4 not driven");
	can_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[1] && !global_peripheral_select[5] |=> second_can_receive)
		else $error("can receive not idle while chip select chosen");
	can_pullup_a: assert property (@(posedge clk_sys) disable iff (rst)
		port_d_peripheral_enable[1] && global_peripheral_select[5]
		|=> port_d_pad_pullup[1] == $past(port_d_pullup_enable[1]))
		else $error("can receive pull-up mismatch");
	serial1_pullup_a: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> port_d_pad_pullup[7:6] == $past(port_d_pullup_enable[7:6]))
		else $error("serial1 pull-up mismatch");
	rx0_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_e_peripheral_enable[1]
		|=> serial0_receive && port_e_pad_oe[1] == $past(port_e_gpio_dir[1]))
		else $error("serial0 receive line not gpio");
	tx1_gpio_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_d_peripheral_enable[6] |=> port_d_pad_out[6] == $past(port_d_gpio_data[6]))
		else $error("line6 not gpio while enable clear");
	rx1_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_d_peripheral_enable[7]
		|=> serial1_receive && port_d_pad_oe[7] == $past(port_d_gpio_dir[7]))
		else $error("serial1 receive line not gpio");
	cs_gpio_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_d_peripheral_enable[5] |=> port_d_pad_oe[5] == $past(port_d_gpio_dir[5]))
		else $error("line5 not gpio while enable clear");
	tx0_gpio_a: assert property (@(posedge clk_sys) disable iff (rst)
		!port_e_peripheral_enable[0] |=> port_e_pad_out[0] == $past(port_e_gpio_data[0]))
		else $error("port e line0 not gpio while enable clear");
endmodule : port_d_e_pin_function_mux

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic       clk_sys, rst, bus_drive_control, ext_bus_active;
	logic       serial0_transmit, serial1_transmit, rx0, rx1, can_rx;
	logic [7:0] pd_per, gps, pd_pu, pd_dir, pd_dat, pd_pad_in, pd_gin, pd_out, pd_oe, pd_pull;
	logic [1:0] pe_per, pe_pu, pe_dir, pe_dat, pe_pad_in, pe_gin, pe_out, pe_oe, pe_pull;
	logic [7:3] cs_n;
	int         n_fail, comparisons;
	////////////////////////////////////////////////////////////////////////////////
	port_d_e_pin_function_mux DUT (.clk_sys(clk_sys), .rst(rst), .port_d_peripheral_enable(pd_per),
		.port_e_peripheral_enable(pe_per), .global_peripheral_select(gps), .port_d_pullup_enable(pd_pu),
		.port_e_pullup_enable(pe_pu), .port_d_gpio_dir(pd_dir), .port_d_gpio_data(pd_dat),
		.port_e_gpio_dir(pe_dir), .port_e_gpio_data(pe_dat), .bus_drive_control(bus_drive_control),
		.chip_select_n(cs_n), .ext_bus_active(ext_bus_active), .serial0_transmit(serial0_transmit),
		.serial1_transmit(serial1_transmit), .serial0_receive(rx0), .serial1_receive(rx1),
		.second_can_receive(can_rx), .port_d_gpio_in(pd_gin), .port_e_gpio_in(pe_gin),
		.port_d_pad_in(pd_pad_in), .port_d_pad_out(pd_out), .port_d_pad_oe(pd_oe),
		.port_d_pad_pullup(pd_pull), .port_e_pad_in(pe_pad_in), .port_e_pad_out(pe_out),
		.port_e_pad_oe(pe_oe), .port_e_pad_pullup(pe_pull));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task summarize;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#200000;
		n_fail++;
		summarize();
	end
	initial
	begin
		n_fail = 0; comparisons = 0;
		rst = 1'b1; bus_drive_control = 1'b0; ext_bus_active = 1'b0;
		serial0_transmit = 1'b1; serial1_transmit = 1'b1; cs_n = 5'h1f;
		pd_per = 8'hc0; pe_per = 2'h3; gps = 8'h00; pd_pu = 8'hfe; pe_pu = 2'h3;
		pd_dir = 8'h00; pd_dat = 8'h00; pe_dir = 2'h0; pe_dat = 2'h0;
		pd_pad_in = 8'hff; pe_pad_in = 2'h3;
		step(10);
		// values while reset is held
		chk(pd_oe, 8'h00);
		chk(pd_pull, 8'hfe);
		chk(pe_pull, 8'h03);
		chk({rx0, rx1, can_rx}, 8'h07);
		rst = 1'b0;
		// serial defaults after release
		serial0_transmit = 1'b0; pe_pad_in = 2'h1; pd_pad_in = 8'h7f;
		step(4);
		chk(pe_oe, 8'h01);
		chk(pe_out[0], 8'h00);
		chk(rx0, 8'h00);
		chk(pd_oe[7:6], 8'h01);
		chk({pd_out[6], rx1}, 8'h02);
		// gpio lines with the select bit flipped
		pd_dir = 8'h2a; pd_dat = 8'h14; gps = 8'h20; pd_pad_in = 8'ha5; pe_pad_in = 2'h2;
		step(4);
		chk(pd_oe[5:1], 8'h15);
		chk(pd_out[5:1], 8'h0a);
		chk(pd_gin[7:1], 8'h52);
		chk(pe_gin, 8'h02);
		// second can receive on line 1
		pd_per = 8'hc2; pd_pu = 8'hfc;
		step(4);
		chk(pd_oe[1], 8'h00);
		chk(can_rx, 8'h00);
		chk(pd_pull[1], 8'h00);
		pd_pad_in = 8'ha7;
		step(4);
		chk(can_rx, 8'h01);
		// chip select 3 on line 1
		gps = 8'h00; ext_bus_active = 1'b1; cs_n = 5'h1e;
		step(1);
		chk({pd_oe[1], pd_out[1]}, 8'h02);
		ext_bus_active = 1'b0;
		step(1);
		chk(pd_oe[1], 8'h00);
		bus_drive_control = 1'b1;
		step(1);
		chk(pd_oe[1], 8'h01);
		// chip selects 4 to 7 on lines 2 to 5
		pd_per = 8'hfe; cs_n = 5'h15;
		step(1);
		chk(pd_oe[5:1], 8'h1f);
		chk(pd_out[5:1], 8'h15);
		bus_drive_control = 1'b0;
		step(1);
		chk(pd_oe[5:1], 8'h00);
		// pull-up control per line
		pd_pu = 8'h3a; pe_pu = 2'h2;
		step(1);
		chk(pd_pull[7:1], 8'h1d);
		chk(pe_pull, 8'h02);
		// every line back to gpio
		bus_drive_control = 1'b1; pd_per = 8'h00; pe_per = 2'h0; pd_dir = 8'hc0; pd_dat = 8'h80;
		pe_dir = 2'h3; pe_dat = 2'h2; pd_pad_in = 8'h00; pe_pad_in = 2'h0;
		step(4);
		chk({pd_oe[7:6], pd_out[7:6]}, 8'h0e);
		chk({pe_oe, pe_out}, 8'h0e);
		chk(pd_oe[5:1], 8'h00);
		chk({rx0, rx1, can_rx}, 8'h07);
		chk(pe_gin, 8'h00);
		// reset in mid-run
		rst = 1'b1;
		step(1);
		chk(pd_oe, 8'h00);
		chk(pd_pull, 8'hfe);
		pd_per = 8'hc0; pe_per = 2'h3; pd_pu = 8'hfe; pe_pu = 2'h3; rst = 1'b0;
		step(2);
		chk(pe_oe, 8'h01);
		chk(pd_oe[7:6], 8'h01);
		summarize();
	end
endmodule : testbench
